// *** logic/odnv_host.sv ***
// host end: fetches the descriptor word and decodes it for software
// assumes: AHB-Lite single-word transfers from one master; device end on the same clock
//
// Behaviour
// [R1] bit 31 flags enable bit present
// [R2] bit 30 gives enable bit polarity
// [R3] bit 29 flags one-time programmable bit
// [R4] bit 28 selects addressed or direct access
// [R5] bit 27 clear: address in byte 0
// [R6] bit 27 set: address in byte 1
// [R7] byte-1 placement not for 8-bit addressing
// [R8] bits 26-24 give bit position
// [R9] addressed: bits 23-16 hold register address
// [R10] direct: bits 23-20 flag supported modes
// [R11] direct: bits 19-16 give dummy cycles
// [R12] single-line mode uses no dummy cycles
// [R13] cleared mode flag is not proof of absence
// [R14] bits 15-8 read opcode, zero unsupported
// [R15] bits 7-0 write opcode, zero unsupported
// [R16] flag bit 28 alone picks field meaning
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "odnv_cfg.svh"
module odnv_host
  import odnv_pkg::*;
(
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  // ahb-lite slave
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // link
  odnv_if.host_mp link
);
  odnv_state_t state_r;
  odnv_state_t state_nxt;
  logic [31:0] word_r;
  logic [31:0] word_nxt;
  logic valid_r;
  logic valid_nxt;
  logic [3:0] ctrl_r;
  logic [3:0] ctrl_nxt;
  logic dwr_r;
  logic dwr_nxt;
  logic [7:0] dadr_r;
  logic [7:0] dadr_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic addr_ph;
  logic fetch_go;
  logic place_bad;
  logic [31:0] dec_c;
  logic [31:0] addr_c;
  logic [31:0] rd_c;
  odnv_aw_t aw;

  // ************
  // bus front end
  // ************
  // zero-wait slave: reads come from a flop loaded in the address phase
  assign addr_ph = I_HSEL & I_HTRANS[1] & I_HREADY;
  assign fetch_go = dwr_r & (dadr_r == `ODNV_OFS_CTRL) & I_HWDATA[`ODNV_CTRL_FETCH];
  assign aw = odnv_aw_t'(ctrl_r[`ODNV_CTRL_AW_HI:`ODNV_CTRL_AW_LO]);

  always_comb begin
    dwr_nxt = addr_ph & I_HWRITE;
    dadr_nxt = addr_ph ? I_HADDR[7:0] : dadr_r;
    ctrl_nxt = ctrl_r;
    if (dwr_r && dadr_r == `ODNV_OFS_CTRL) begin
      // fetch is a strobe, never stored
      ctrl_nxt = {I_HWDATA[`ODNV_CTRL_SINGLE:`ODNV_CTRL_AW_LO], 1'b0};
    end
  end

  // ************
  // fetch sequencer
  // ************
  // a fetch strobe while waiting is dropped; software polls valid
  always_comb begin
    state_nxt = state_r;
    word_nxt = word_r;
    valid_nxt = valid_r;
    case (state_r)
      ODNV_S_IDLE: begin
        if (fetch_go) begin
          state_nxt = ODNV_S_WAIT;
          valid_nxt = 1'b0;
        end
      end
      ODNV_S_WAIT: begin
        if (link.ack) begin
          state_nxt = ODNV_S_IDLE;
          word_nxt = link.word;
          valid_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = ODNV_S_IDLE;
      end
    endcase
  end

  assign link.req = (state_r == ODNV_S_WAIT);

  // ************
  // field decode
  // ************
  always_comb begin
    dec_c = 32'h0000_0000;
    dec_c[0] = word_r[`ODNV_B_AVAIL]; // [R1]
    // level to store that turns the mode on
    dec_c[1] = ~word_r[`ODNV_B_POL]; // [R2]
    dec_c[2] = word_r[`ODNV_B_OTP]; // [R3]
    dec_c[3] = word_r[`ODNV_B_ADDRD]; // [R4]
    dec_c[6:4] = word_r[`ODNV_B_POS_HI:`ODNV_B_POS_LO]; // [R8]
    dec_c[8] = (word_r[`ODNV_B_RD_HI:`ODNV_B_RD_LO] != `ODNV_OP_NONE); // [R14]
    dec_c[9] = (word_r[`ODNV_B_WR_HI:`ODNV_B_WR_LO] != `ODNV_OP_NONE); // [R15]
    if (!word_r[`ODNV_B_ADDRD]) begin // [R16]
      // flags only say the listed modes work; others may too
      dec_c[15:12] = word_r[`ODNV_B_MODE_HI:`ODNV_B_MODE_LO]; // [R10] [R13]
      // single-line commands never take dummy cycles
      if (!ctrl_r[`ODNV_CTRL_SINGLE]) begin // [R12]
        dec_c[19:16] = word_r[`ODNV_B_DUM_HI:`ODNV_B_DUM_LO]; // [R11]
      end
    end
  end

  // ************
  // command address placement
  // ************
  // 8-bit spaces cannot carry byte 1: flagged and the address left at zero
  // 24 and 32 bit spaces both take the byte-1 form
  assign place_bad = word_r[`ODNV_B_ADDRD] & word_r[`ODNV_B_BYTE1] & (aw == ODNV_AW_8); // [R7]

  always_comb begin
    addr_c = 32'h0000_0000;
    if (word_r[`ODNV_B_ADDRD] && !place_bad) begin // [R16]
      if (word_r[`ODNV_B_BYTE1]) begin
        addr_c[15:8] = word_r[`ODNV_B_FLD_HI:`ODNV_B_FLD_LO]; // [R6] [R9]
      end else begin
        addr_c[7:0] = word_r[`ODNV_B_FLD_HI:`ODNV_B_FLD_LO]; // [R5] [R9]
      end
    end
  end

  // ************
  // read mux
  // ************
  always_comb begin
    case (I_HADDR[7:0])
      `ODNV_OFS_CTRL: rd_c = {28'h0000000, ctrl_r};
      `ODNV_OFS_STAT: rd_c = {29'h0, place_bad, valid_r, link.req};
      `ODNV_OFS_WORD: rd_c = word_r;
      `ODNV_OFS_DEC: rd_c = dec_c;
      `ODNV_OFS_ADDR: rd_c = addr_c;
      `ODNV_OFS_OPS: rd_c = {16'h0000, word_r[`ODNV_B_RD_HI:`ODNV_B_WR_LO]};
      default: rd_c = 32'h0000_0000;
    endcase
    rdata_nxt = (addr_ph && !I_HWRITE) ? rd_c : rdata_r;
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      ctrl_r <= `ODNV_CTRL_RST;
      dwr_r <= 1'b0;
      dadr_r <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      dwr_r <= dwr_nxt;
      dadr_r <= dadr_nxt;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      state_r <= ODNV_S_IDLE;
      word_r <= `ODNV_WORD_RST;
      valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      word_r <= word_nxt;
      valid_r <= valid_nxt;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign O_HRDATA = rdata_r;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;
endmodule
`default_nettype wire

// *** logic/odnv_cfg.svh ***
// constants of the octal double-rate enable-bit descriptor word
// assumes: included by bare name wherever offsets or field positions are needed
`ifndef ODNV_CFG_SVH
`define ODNV_CFG_SVH

// ************
// field positions in the descriptor word
// ************
`define ODNV_B_AVAIL 31
`define ODNV_B_POL 30
`define ODNV_B_OTP 29
`define ODNV_B_ADDRD 28
`define ODNV_B_BYTE1 27
`define ODNV_B_POS_HI 26
`define ODNV_B_POS_LO 24
`define ODNV_B_FLD_HI 23
`define ODNV_B_FLD_LO 16
`define ODNV_B_MODE_HI 23
`define ODNV_B_MODE_LO 20
`define ODNV_B_DUM_HI 19
`define ODNV_B_DUM_LO 16
`define ODNV_B_RD_HI 15
`define ODNV_B_RD_LO 8
`define ODNV_B_WR_HI 7
`define ODNV_B_WR_LO 0
`define ODNV_OP_NONE 8'h00

// ************
// controller register offsets (byte addresses)
// ************
`define ODNV_OFS_CTRL 8'h00
`define ODNV_OFS_STAT 8'h04
`define ODNV_OFS_WORD 8'h08
`define ODNV_OFS_DEC 8'h0c
`define ODNV_OFS_ADDR 8'h10
`define ODNV_OFS_OPS 8'h14

// ************
// controller register fields and reset values
// ************
`define ODNV_CTRL_FETCH 0
`define ODNV_CTRL_AW_LO 1
`define ODNV_CTRL_AW_HI 2
`define ODNV_CTRL_SINGLE 3
`define ODNV_CTRL_RST 4'h0
`define ODNV_WORD_RST 32'h0000_0000

`endif

// *** logic/odnv_pkg.sv ***
// types used by the host end of the descriptor link
// assumes: compiled before the interface and the two ends
package odnv_pkg;
  // host fetch sequencer
  typedef enum logic [1:0] {
    ODNV_S_IDLE = 2'b01,
    ODNV_S_WAIT = 2'b10
  } odnv_state_t;

  // address space width chosen by software
  typedef enum logic [1:0] {
    ODNV_AW_8 = 2'h0,
    ODNV_AW_24 = 2'h1,
    ODNV_AW_32 = 2'h2
  } odnv_aw_t;
endpackage

// *** logic/odnv_if.sv ***
// link that carries the descriptor word from the device end to the host end
// assumes: both ends run on the same clock; no clocking block is used
`timescale 1ns/1ns
`default_nettype none
interface odnv_if;
  logic req;
  logic ack;
  logic [31:0] word;

  modport dev_mp (
    input req,
    output ack,
    output word
  );

  modport host_mp (
    output req,
    input ack,
    input word
  );
endinterface
`default_nettype wire

// *** logic/odnv_dev.sv ***
// device end: assembles the descriptor word from its straps and serves it
// assumes: the host holds req until ack; straps are static logic on I_CLK_SYS
`timescale 1ns/1ns
`default_nettype none
`include "odnv_cfg.svh"
module odnv_dev
  import odnv_pkg::*;
(
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  // descriptor contents
  input wire logic I_AVAIL,
  input wire logic I_INVERTED,
  input wire logic I_ONE_TIME,
  input wire logic I_ADDRESSED,
  input wire logic I_BYTE1,
  input wire logic [2:0] I_BIT_POS,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [3:0] I_MODES,
  input wire logic [3:0] I_DUMMY,
  input wire logic [7:0] I_RD_OP,
  input wire logic [7:0] I_WR_OP,
  // link
  odnv_if.dev_mp link
);
  logic [31:0] word_c;
  logic [31:0] word_r;
  logic [31:0] word_nxt;
  logic ack_r;
  logic ack_nxt;

  // ************
  // word assembly
  // ************
  always_comb begin
    word_c = `ODNV_WORD_RST;
    word_c[`ODNV_B_AVAIL] = I_AVAIL; // [R1]
    word_c[`ODNV_B_POL] = I_INVERTED; // [R2]
    word_c[`ODNV_B_OTP] = I_ONE_TIME; // [R3]
    word_c[`ODNV_B_ADDRD] = I_ADDRESSED; // [R4]
    word_c[`ODNV_B_BYTE1] = I_BYTE1; // [R5] [R6]
    word_c[`ODNV_B_POS_HI:`ODNV_B_POS_LO] = I_BIT_POS; // [R8]
    if (I_ADDRESSED) begin
      word_c[`ODNV_B_FLD_HI:`ODNV_B_FLD_LO] = I_REG_ADDR; // [R9]
    end else begin
      word_c[`ODNV_B_MODE_HI:`ODNV_B_MODE_LO] = I_MODES; // [R10]
      word_c[`ODNV_B_DUM_HI:`ODNV_B_DUM_LO] = I_DUMMY; // [R11]
    end
    // a zero opcode tells the host the access does not exist
    word_c[`ODNV_B_RD_HI:`ODNV_B_RD_LO] = I_RD_OP; // [R14]
    word_c[`ODNV_B_WR_HI:`ODNV_B_WR_LO] = I_WR_OP; // [R15]
  end

  // ************
  // answer: one cycle after req, word held until the next request
  // ************
  always_comb begin
    ack_nxt = link.req & ~ack_r;
    word_nxt = (link.req & ~ack_r) ? word_c : word_r;
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_NRST) begin
      ack_r <= 1'b0;
      word_r <= `ODNV_WORD_RST;
    end else begin
      ack_r <= ack_nxt;
      word_r <= word_nxt;
    end
  end

  assign link.ack = ack_r;
  assign link.word = word_r;
endmodule
`default_nettype wire

// *** tb/odnv_properties.sv ***
// link checker for the descriptor handshake
// assumes: instanced in the bench beside the link
`timescale 1ns/1ns
`default_nettype none
module odnv_properties (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  // link
  input wire logic i_req,
  input wire logic i_ack,
  input wire logic [31:0] i_word
);
  // ***
  // handshake
  // ***
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  property p_ack_pulse; i_ack |=> !i_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack too long");
  property p_ack_soon; $rose(i_req) |=> i_ack; endproperty
  a_ack_soon: assert property (p_ack_soon)
    else $error("ack late");
  property p_ack_cause; i_ack |-> $past(i_req); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without req");
  property p_no_ack; !i_req |=> !i_ack; endproperty
  a_no_ack: assert property (p_no_ack)
    else $error("ack while idle");
  property p_req_drop; i_ack |=> !i_req; endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("req held after ack");
  property p_req_hold; i_req && !i_ack |=> i_req; endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("req dropped early");
  property p_fell_req; $fell(i_req) |-> $past(i_ack); endproperty
  a_fell_req: assert property (p_fell_req)
    else $error("req fell without ack");
  // word may only move with ack, else host could latch a torn value
  property p_word_hold; !i_ack |-> $stable(i_word); endproperty
  a_word_hold: assert property (p_word_hold)
    else $error("word moved without ack");
endmodule
`default_nettype wire

// *** tb/odnv_test.sv ***
// bench: both ends joined, host driven over ahb-lite
// assumes: hreadyout feeds hready; straps random per fetch
`timescale 1ns/1ns
`default_nettype none
`include "odnv_cfg.svh"
module odnv_test;
  import odnv_pkg::*;
  logic clk = 0;
  logic nrst = 0;
  logic [1:0] htrans = 0;
  logic hwrite = 0;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata;
  logic hrdy;
  logic hresp;
  logic av = 0, iv = 0, ot = 0, ad = 0, b1 = 0;
  logic [2:0] pos = 0;
  logic [7:0] ra = 0, rd = 0, wr = 0;
  logic [3:0] md = 0, dm = 0;
  int n_mismatch = 0;
  int cmp_count = 0;
  int seed = 13902;
  odnv_if lk();
  odnv_dev odnv_dev_inst(.I_CLK_SYS(clk), .I_NRST(nrst), .I_AVAIL(av), .I_INVERTED(iv),
    .I_ONE_TIME(ot), .I_ADDRESSED(ad), .I_BYTE1(b1), .I_BIT_POS(pos), .I_REG_ADDR(ra),
    .I_MODES(md), .I_DUMMY(dm), .I_RD_OP(rd), .I_WR_OP(wr), .link(lk));
  odnv_host odnv_host_inst(.I_CLK_SYS(clk), .I_NRST(nrst), .I_HSEL(1'b1), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hrdy),
    .O_HRDATA(hrdata), .O_HREADYOUT(hrdy), .O_HRESP(hresp), .link(lk));
  odnv_properties odnv_properties_inst(.I_CLK_SYS(clk), .I_NRST(nrst), .i_req(lk.req),
    .i_ack(lk.ack), .i_word(lk.word));
  initial begin
    forever #5 clk = ~clk;
  end
  // ***
  // tasks and expectations
  // ***
  task end_sim;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task rdy;
    int k;
    k = 0;
    @(posedge clk);
    while (hrdy !== 1'b1) begin
      @(posedge clk);
      k++;
      if (k > 50) begin
        n_mismatch++;
        end_sim;
      end
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask
  function automatic logic [31:0] ew();
    ew = {av, iv, ot, ad, b1, pos, ad ? ra : {md, dm}, rd, wr};
  endfunction
  function automatic logic [31:0] edec(input logic sg);
    edec = {12'h0, (ad | sg) ? 4'h0 : dm, ad ? 4'h0 : md, 2'h0, wr != 0, rd != 0, 1'b0, pos,
      ad, ot, ~iv, av};
  endfunction
  // ***
  // main sequence
  // ***
  initial begin
    int i, j;
    logic [1:0] aw;
    logic sg, e;
    logic [31:0] q;
    logic [63:0] r;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    ahb(1'b0, `ODNV_OFS_WORD, 32'h0, q);
    chk(q, `ODNV_WORD_RST);
    for (i = 0; i < 40; i++) begin
      r = {$random(seed), $random(seed)};
      {av, iv, ot, ad, b1, pos, ra, md, dm, rd, wr} <= r[39:0];
      aw = 2'($unsigned($random(seed)) % 3);
      sg = r[40];
      // corners: byte-1 with 8 and 24 bit widths, no opcodes
      case (i)
        0: begin ad <= 1'b1; b1 <= 1'b1; aw = 2'h0; end
        1: begin ad <= 1'b1; b1 <= 1'b1; aw = 2'h1; end
        2: begin ad <= 1'b0; rd <= 8'h0; wr <= 8'h0; sg = 1'b1; end
        default: ;
      endcase
      ahb(1'b1, `ODNV_OFS_CTRL, {28'h0, sg, aw, 1'b1}, q);
      for (j = 0; j < 20; j++) begin
        ahb(1'b0, `ODNV_OFS_STAT, 32'h0, q);
        if (q[1] === 1'b1) break;
      end
      if (j == 20) begin
        n_mismatch++;
        end_sim;
      end
      e = ad & b1 & (aw == 2'h0);
      chk(q, {29'h0, e, 2'b10});
      ahb(1'b0, `ODNV_OFS_WORD, 32'h0, q);
      chk(q, ew());
      ahb(1'b0, `ODNV_OFS_DEC, 32'h0, q);
      chk(q, edec(sg));
      ahb(1'b0, `ODNV_OFS_ADDR, 32'h0, q);
      chk(q, (!ad || e) ? 32'h0 : b1 ? {16'h0, ra, 8'h0} : {24'h0, ra});
      ahb(1'b0, `ODNV_OFS_OPS, 32'h0, q);
      chk(q, {16'h0, rd, wr});
    end
    // read-only and unmapped places
    ahb(1'b1, `ODNV_OFS_WORD, 32'hffff_ffff, q);
    ahb(1'b0, `ODNV_OFS_WORD, 32'h0, q);
    chk(q, ew());
    ahb(1'b0, 8'h18, 32'h0, q);
    chk(q, 32'h0);
    ahb(1'b0, `ODNV_OFS_CTRL, 32'h0, q);
    chk(q, {28'h0, sg, aw, 1'b0});
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, hrdy}, 32'h1);
    end_sim;
  end
endmodule
`default_nettype wire
